// ==== alp_tunnel_info_header_bench.sv ====
// Purpose: Drives the source over AXI4-Lite and checks the scheduler
// Assumes: Both ends joined through one link interface
// Notes:   Scheduler output stalls one cycle in four to load the link
`timescale 1ns/1ns
module alp_tunnel_info_header_bench;
   import ath_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, hdr_valid;
   logic        hdr_best_effort, hdr_err, out_valid, out_ready;
   logic        out_first, out_last, was_end;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, hdr_sub_stream, out_data;
   logic [31:0] s_axi_wdata, s_axi_rdata, hdr_deadline, g_dl;
   logic [3:0]  s_axi_wstrb, hdr_flags;
   logic [1:0]  s_axi_bresp, s_axi_rresp, hdr_wake, r;
   logic [15:0] hdr_length, cyc;
   logic [5:0]  hdr_pipe_index, out_pipe_index;
   logic [36:0] g_hdr;
   logic [15:0] got[$];
   logic [31:0] d;
   int          num_errors, tests_run, n_hdr;
   ath_link_if link ();
   ath_src u_ath_src (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link);
   ath_sched_rx u_ath_sched_rx (.aclk, .aresetn, .link, .hdr_valid,
      .hdr_length, .hdr_sub_stream, .hdr_pipe_index, .hdr_flags, .hdr_wake,
      .hdr_deadline, .hdr_best_effort, .hdr_err, .out_valid, .out_ready,
      .out_data, .out_pipe_index, .out_first, .out_last);
   ath_link_checker u_ath_link_checker (.aclk(aclk), .aresetn(aresetn),
      .tvalid(link.tvalid), .tready(link.tready), .tdata(link.tdata),
      .tstart(link.tstart), .tend(link.tend));
   // ----------------------------------------------------------------
   // Clock, monitor and watchdog
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 16'h0001;
      out_ready <= (cyc[1:0] != 2'h3);
      if (hdr_valid === 1'b1) begin
         g_hdr = {hdr_length, hdr_sub_stream, hdr_pipe_index, hdr_flags,
                  hdr_wake, hdr_best_effort};
         g_dl = hdr_deadline;
         n_hdr++;
      end
      if (hdr_err === 1'b1)
         chk(1, 0);
      if (out_valid === 1'b1 && out_ready === 1'b1)
         got.push_back({out_last, out_first, out_pipe_index, out_data});
      if (link.tvalid === 1'b1 && link.tready === 1'b1) begin
         if (was_end)
            chk(link.tstart, 1);
         was_end = link.tend;
      end
   end
   initial begin
      #100000;
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize();
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v  = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Frames one packet; split marks the byte that closes the payload
   task automatic pkt(input logic [31:0] hw, input logic [5:0] fl,
                      input logic [31:0] dl, input int split);
      logic [15:0] n;
      logic [1:0]  wk;
      logic        be;
      int          h0;
      n  = hw[15:0];
      wk = fl[FL_SIG] ? {fl[FL_WAKE_ACT], fl[FL_WAKE_NEW]} : WAKE_NONE;
      be = !fl[FL_DL] || dl == DEADLINE_BEST;
      h0 = n_hdr;
      got.delete();
      axw(OFS_HDR, hw, r);
      axw(OFS_FLAGS, {26'h0, fl}, r);
      axw(OFS_DEADLINE, dl, r);
      axw(OFS_CTRL, 32'h0000_0001, r);
      chk(r, RESP_OKAY);
      if (n != 16'h0000) begin
         axw(OFS_HDR, 32'hFFFF_FFFF, r);
         chk(r, RESP_SLVERR);
      end
      for (int i = 0; i < n; i++) begin
         axw(OFS_DATA, {23'h0, i == split, 8'(hw[23:16] + i)}, r);
         chk(r, RESP_OKAY);
      end
      for (int k = 0; k < 200 && (got.size() < n || n_hdr == h0); k++)
         @(posedge aclk);
      chk(got.size(), n);
      chk(g_hdr, {hw[15:0], hw[23:16], hw[29:24], fl[FL_SIG], fl[FL_MAP],
                  fl[FL_ENTRY], fl[FL_DL], wk, be});
      chk(g_dl, fl[FL_DL] ? dl : DEADLINE_BEST);
      for (int i = 0; i < got.size(); i++)
         chk(got[i], {i == n - 1, i == 0, hw[29:24], 8'(hw[23:16] + i)});
      axr(OFS_STATUS, d, r);
      chk(d, 32'h0000_0000);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, out_ready, was_end} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      cyc = 16'h0000;
      n_hdr = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axr(8'h40, d, r);
      chk({d, r}, {32'h0, RESP_SLVERR});
      axw(OFS_DATA, 32'h0000_0055, r);
      chk(r, RESP_SLVERR);
      pkt(32'h2AC3_0003, 6'h33, 32'h0000_0000, 99);
      pkt(32'h3F00_0004, 6'h1C, 32'hFEDC_BA98, 1);
      pkt(32'h00FF_0000, 6'h08, 32'h0000_0000, 99);
      pkt(32'h015A_0002, 6'h21, 32'h1111_2222, 99);
      summarize();
   end
endmodule

// ==== ath_link_checker.sv ====
// Purpose: Watches the byte link between source and scheduler
// Assumes: One clock, reset synchronous and active low
// Notes:   Follows header and payload position from the bytes taken
`timescale 1ns/1ns
module ath_link_checker (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       tvalid,
   input wire logic       tready,
   input wire logic [7:0] tdata,
   input wire logic       tstart,
   input wire logic       tend
);
   import ath_pkg::*;
   // ----------------------------------------------------------------
   // Position tracking
   // ----------------------------------------------------------------
   logic        in_pay, sig, dl, after_end, take, hdr_last;
   logic [3:0]  idx;
   logic [15:0] len, rem;
   assign take     = tvalid && tready;
   assign hdr_last = (idx == HDR_LAST_BASE && !dl) || idx == HDR_LAST_DL;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_pay    <= 1'b0;
         idx       <= 4'h0;
         after_end <= 1'b0;
      end else if (take) begin
         after_end <= tend;
         if (in_pay) begin
            rem    <= rem - 16'h0001;
            in_pay <= (rem != 16'h0001);
         end else begin
            idx <= hdr_last ? 4'h0 : idx + 4'h1;
            if (idx == 4'h0)
               len[15:8] <= tdata;
            if (idx == 4'h1)
               len[7:0] <= tdata;
            if (idx == 4'h3)
               sig <= tdata[1];
            if (idx == HDR_FLAG_BYTE)
               dl <= tdata[FLAG_DL_BIT];
            if (hdr_last) begin
               in_pay <= (len != 16'h0000);
               rem    <= len;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_hdr_take;
      take && !in_pay;
   endsequence
   sequence s_pay_take;
      take && in_pay;
   endsequence
   a_offer_hold: assert property (tvalid && !tready |=> tvalid
      && $stable(tdata) && $stable(tstart) && $stable(tend))
      else $error("link byte changed before it was taken");
   a_hdr_no_end: assert property (s_hdr_take |-> !tend)
      else $error("header byte closes the payload");
   a_rsvd_zero: assert property (s_hdr_take ##0
      (idx > 4'h4 && idx < 4'h8) |-> tdata == 8'h00)
      else $error("reserved header byte not zero");
   a_nibble_zero: assert property (s_hdr_take ##0
      idx == HDR_FLAG_BYTE |-> tdata[3:0] == 4'h0)
      else $error("reserved bits of flag byte not zero");
   a_wake_quiet: assert property (s_hdr_take ##0
      (idx == HDR_FLAG_BYTE && !sig) |-> tdata[5:4] == WAKE_NONE)
      else $error("wake bits set without signaling flag");
   a_hdr_burst: assert property (s_hdr_take ##0 !hdr_last |=> tvalid)
      else $error("gap inside header");
   a_pay_single: assert property (s_pay_take |=> !tvalid)
      else $error("payload byte offered back to back");
   a_rx_pause: assert property (s_pay_take |=> !tready)
      else $error("scheduler ready while byte held");
   a_split_resume: assert property (take && after_end |-> tstart)
      else $error("byte after payload end lacks start mark");
   a_reset_idle: assert property ($rose(aresetn) |-> !tvalid && tready)
      else $error("link not idle after reset");
endmodule

// ==== ath_link_if.sv ====
// Purpose: Byte stream carrying tunnel payloads between source and scheduler
// Assumes: Byte moves when tvalid and tready are both high
// Notes:   tstart marks first byte of a tunnel payload, tend its last
`timescale 1ns/1ns
interface ath_link_if;
   logic       tvalid;
   logic       tready;
   logic [7:0] tdata;
   logic       tstart;
   logic       tend;

   modport src (
      output tvalid,
      input  tready,
      output tdata,
      output tstart,
      output tend
   );

   modport sched (
      input  tvalid,
      output tready,
      input  tdata,
      input  tstart,
      input  tend
   );
endinterface

// ==== ath_pkg.sv ====
// Purpose: Shared constants and types for the tunnel information header
// Assumes: One synchronous clock domain, byte-wide link
// Notes:   Header is 8 bytes, or 12 with the deadline field
package ath_pkg;
   // ----------------------------------------------------------------
   // Header geometry
   // ----------------------------------------------------------------
   localparam int unsigned HDR_BYTES_BASE  = 8;
   localparam int unsigned HDR_BYTES_DL    = 12;
   localparam logic [3:0]  HDR_LAST_BASE   = 4'h7;
   localparam logic [3:0]  HDR_LAST_DL     = 4'hB;
   localparam logic [3:0]  HDR_FLAG_BYTE   = 4'h4;
   localparam int unsigned FLAG_DL_BIT     = 6;
   localparam logic [27:0] HDR_RSVD        = 28'h000_0000;
   localparam logic [1:0]  WAKE_NONE       = 2'h0;
   localparam logic [31:0] DEADLINE_BEST   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Source register map (AXI4-Lite, byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_HDR      = 8'h04;
   localparam logic [7:0] OFS_FLAGS    = 8'h08;
   localparam logic [7:0] OFS_DEADLINE = 8'h0C;
   localparam logic [7:0] OFS_DATA     = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam int unsigned CTRL_START  = 0;
   localparam int unsigned DATA_TEND   = 8;
   localparam int unsigned FL_SIG      = 0;
   localparam int unsigned FL_MAP      = 1;
   localparam int unsigned FL_ENTRY    = 2;
   localparam int unsigned FL_DL       = 3;
   localparam int unsigned FL_WAKE_ACT = 4;
   localparam int unsigned FL_WAKE_NEW = 5;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      ATH_SRC_IDLE = 2'b00,
      ATH_SRC_HDR  = 2'b01,
      ATH_SRC_PAY  = 2'b10
   } ath_src_state_t;

   typedef enum logic [1:0] {
      ATH_RX_HUNT = 2'b00,
      ATH_RX_HDR  = 2'b01,
      ATH_RX_PAY  = 2'b10
   } ath_rx_state_t;
endpackage

// ==== ath_sched_rx.sv ====
// Purpose: Scheduler end: parses headers and tags bytes with their pipe
// Assumes: Source frames the stream correctly; errors only resync
// Notes:   One output byte buffered, so tready falls while it waits
`timescale 1ns/1ns
module ath_sched_rx (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   ath_link_if.sched        link,
   output logic             hdr_valid,
   output logic [15:0]      hdr_length,
   output logic [7:0]       hdr_sub_stream,
   output logic [5:0]       hdr_pipe_index,
   output logic [3:0]       hdr_flags,
   output logic [1:0]       hdr_wake,
   output logic [31:0]      hdr_deadline,
   output logic             hdr_best_effort,
   output logic             hdr_err,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [7:0]       out_data,
   output logic [5:0]       out_pipe_index,
   output logic             out_first,
   output logic             out_last
);
   import ath_pkg::*;

   typedef struct packed {
      ath_rx_state_t st;
      logic [95:0] shift;
      logic [3:0]  idx;
      logic        dl;
      logic [15:0] remain;
      logic        first;
      logic        rdy;
      logic        hv;
      logic [15:0] len;
      logic [7:0]  sid;
      logic [5:0]  pipe;
      logic [3:0]  flags;
      logic [1:0]  wake;
      logic [31:0] deadline;
      logic        best;
      logic        err;
      logic        ov;
      logic [7:0]  od;
      logic        of;
      logic        ol;
   } ath_rx_s_t;

   ath_rx_s_t   s_reg;
   ath_rx_s_t   s_next;
   logic        take;
   logic [95:0] sh;
   logic [63:0] base;

   assign take = link.tvalid && s_reg.rdy;
   assign sh   = {s_reg.shift[87:0], link.tdata};               // R17
   assign base = s_reg.dl ? sh[95:32] : sh[63:0];

   always_comb begin
      s_next     = s_reg;
      s_next.hv  = 1'b0;
      s_next.err = 1'b0;
      if (s_reg.ov && out_ready) begin
         s_next.ov = 1'b0;
      end
      if (take) begin
         case (s_reg.st)
            ATH_RX_HUNT: begin
               if (link.tstart) begin
                  s_next.st    = ATH_RX_HDR;
                  s_next.shift = sh;
                  s_next.idx   = 4'h1;
               end
            end
            ATH_RX_HDR: begin
               s_next.shift = sh;
               s_next.idx   = s_reg.idx + 4'h1;
               if (s_reg.idx == HDR_FLAG_BYTE) begin
                  s_next.dl = link.tdata[FLAG_DL_BIT];          // R10
               end
               if (link.tend) begin
                  s_next.err = 1'b1;
                  s_next.st  = ATH_RX_HUNT;
               end else if (link.tstart && s_reg.idx != 4'h0) begin
                  s_next.err = 1'b1;
                  s_next.idx = 4'h1;
               end else if ((s_reg.idx == HDR_LAST_BASE && !s_reg.dl) ||
                            s_reg.idx == HDR_LAST_DL) begin
                  s_next.hv       = 1'b1;
                  s_next.idx      = 4'h0;
                  s_next.len      = base[63:48];                // R2
                  s_next.sid      = base[47:40];
                  s_next.pipe     = base[39:34];
                  s_next.flags    = base[33:30];
                  s_next.wake     = base[33] ? base[29:28]
                                             : WAKE_NONE;       // R11
                  s_next.deadline = s_reg.dl ? sh[31:0]
                                             : DEADLINE_BEST;
                  s_next.best     = !s_reg.dl ||
                                    sh[31:0] == DEADLINE_BEST;  // R12
                  s_next.remain   = base[63:48];                // R4
                  s_next.first    = 1'b1;
                  if (base[63:48] != 16'h0000) begin
                     s_next.st = ATH_RX_PAY;
                  end
               end
            end
            ATH_RX_PAY: begin
               // A tstart here is a continuation of the split packet
               s_next.ov     = 1'b1;                            // R4
               s_next.od     = link.tdata;
               s_next.of     = s_reg.first;
               s_next.ol     = (s_reg.remain == 16'h0001);
               s_next.first  = 1'b0;
               s_next.remain = s_reg.remain - 16'h0001;
               if (s_reg.remain == 16'h0001) begin
                  s_next.st = link.tend ? ATH_RX_HUNT : ATH_RX_HDR;
               end
            end
            default: s_next.st = ATH_RX_HUNT;
         endcase
      end
      s_next.rdy = !s_next.ov;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg     <= '0;
         s_reg.st  <= ATH_RX_HUNT;
         s_reg.rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign link.tready     = s_reg.rdy;
   assign hdr_valid       = s_reg.hv;
   assign hdr_length      = s_reg.len;
   assign hdr_sub_stream  = s_reg.sid;
   assign hdr_pipe_index  = s_reg.pipe;
   assign hdr_flags       = s_reg.flags;
   assign hdr_wake        = s_reg.wake;
   assign hdr_deadline    = s_reg.deadline;
   assign hdr_best_effort = s_reg.best;
   assign hdr_err         = s_reg.err;
   assign out_valid       = s_reg.ov;
   assign out_data        = s_reg.od;
   assign out_pipe_index  = s_reg.pipe;                         // R6
   assign out_first       = s_reg.of;
   assign out_last        = s_reg.ol;
endmodule

// ==== ath_src.sv ====
// Purpose: Packet source end: frames each inner packet with its header
// Assumes: Software drives it over AXI4-Lite, one byte per DATA write
// Notes:   Outside IDLE a DATA write is answered only once its byte leaves on the link
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns

//Function
// R1: every packet starting in a payload gets header
// R2: field order length, id, pipe, flags, wake, reserved
// R3: length counts whole inner packet bytes
// R4: length is full size even when split
// R5: sub-stream id follows the length
// R6: scheduler routes by pipe index
// R7: signaling flag set when table present
// R8: mapping flag set when table present
// R9: entry marker on every access point packet
// R10: deadline field present only with its flag
// R11: wake bits only with signaling flag, else 00
// R12: deadline zero means best effort
// R13: one stream per pipe, many pipes allowed
// R14: payloads carry packets with their headers
// R15: first wake bit requests non-zero wake
// R16: second wake bit marks new wake alert
// R17: fields sent MSB first, no padding
module ath_src (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   ath_link_if.src          link
);
   import ath_pkg::*;

   typedef struct packed {
      ath_src_state_t st;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [15:0] length;
      logic [7:0]  sub_stream;
      logic [5:0]  pipe_index;
      logic [5:0]  flags;
      logic [31:0] deadline;
      logic [95:0] shift;
      logic [3:0]  idx;
      logic [15:0] remain;
      logic        dwait;
      logic        tv;
      logic [7:0]  td;
      logic        ts;
      logic        te;
      logic        first;
   } ath_src_s_t;

   ath_src_s_t s_reg;
   ath_src_s_t s_next;
   logic       wake_act;
   logic       wake_new;
   logic       sent;
   logic       both;
   logic [1:0] wake;
   logic [3:0] hdr_last;

   // ----------------------------------------------------------------
   // Header build
   // ----------------------------------------------------------------
   assign wake_act = s_reg.flags[FL_WAKE_ACT];                  // R15
   assign wake_new = s_reg.flags[FL_WAKE_NEW];                  // R16
   assign wake     = s_reg.flags[FL_SIG] ? {wake_act, wake_new}
                                         : WAKE_NONE;           // R11
   assign hdr_last = s_reg.flags[FL_DL] ? HDR_LAST_DL
                                        : HDR_LAST_BASE;        // R10
   assign sent     = s_reg.tv && link.tready;
   assign both     = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

   always_comb begin
      s_next = s_reg;
      // ----------------------------------------------------------------
      // AXI4-Lite capture, either order
      // ----------------------------------------------------------------
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.aw_got  = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.w_got  = 1'b1;
         s_next.w_data = s_axi_wdata;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = RESP_OKAY;
         case (s_axi_araddr)
            OFS_HDR:
               s_next.rdata = {2'h0, s_reg.pipe_index, s_reg.sub_stream,
                               s_reg.length};
            OFS_FLAGS:    s_next.rdata = {26'h000_0000, s_reg.flags};
            OFS_DEADLINE: s_next.rdata = s_reg.deadline;
            OFS_STATUS:
               s_next.rdata = {14'h0000, s_reg.st, s_reg.remain};
            OFS_CTRL:     s_next.rdata = 32'h0000_0000;
            default: begin
               s_next.rdata = 32'h0000_0000;
               s_next.rresp = RESP_SLVERR;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // Link byte accepted
      // ----------------------------------------------------------------
      if (sent) begin
         s_next.tv    = 1'b0;
         s_next.first = s_reg.te;
         if (s_reg.st == ATH_SRC_HDR) begin
            s_next.shift = {s_reg.shift[87:0], 8'h00};         // R17
            s_next.idx   = s_reg.idx + 4'h1;
            if (s_reg.idx == hdr_last) begin
               s_next.st = (s_reg.length == 16'h0000) ? ATH_SRC_IDLE
                                                      : ATH_SRC_PAY;
            end
         end else if (s_reg.dwait) begin
            s_next.dwait  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = RESP_OKAY;
            s_next.remain = s_reg.remain - 16'h0001;
            if (s_reg.remain == 16'h0001) begin
               s_next.st = ATH_SRC_IDLE;
            end
         end
      end
      if (s_next.st == ATH_SRC_HDR && !s_next.tv) begin
         s_next.tv = 1'b1;
         s_next.td = s_next.shift[95:88];
         s_next.ts = s_next.first;
         s_next.te = 1'b0;                                      // R1
      end

      // ----------------------------------------------------------------
      // Write actions
      // ----------------------------------------------------------------
      if (both && !s_reg.dwait) begin
         s_next.bresp = RESP_OKAY;
         s_next.bvalid = 1'b1;
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         case (s_reg.aw_addr)
            OFS_CTRL: begin
               if (!s_reg.w_data[CTRL_START]) begin
                  s_next.bresp = RESP_OKAY;
               end else if (s_reg.st == ATH_SRC_IDLE) begin
                  s_next.st     = ATH_SRC_HDR;
                  s_next.idx    = 4'h0;
                  s_next.remain = s_reg.length;                 // R3 R4
                  s_next.shift  = {s_reg.length, s_reg.sub_stream,
                                   s_reg.pipe_index,
                                   s_reg.flags[FL_SIG],         // R7
                                   s_reg.flags[FL_MAP],         // R8
                                   s_reg.flags[FL_ENTRY],       // R9
                                   s_reg.flags[FL_DL], wake,
                                   HDR_RSVD,
                                   s_reg.deadline};             // R2 R5 R10
               end else begin
                  s_next.bresp = RESP_SLVERR;
               end
            end
            OFS_HDR, OFS_FLAGS, OFS_DEADLINE: begin
               if (s_reg.st != ATH_SRC_IDLE) begin
                  s_next.bresp = RESP_SLVERR;
               end else if (s_reg.aw_addr == OFS_HDR) begin
                  s_next.length     = s_reg.w_data[15:0];
                  s_next.sub_stream = s_reg.w_data[23:16];
                  s_next.pipe_index = s_reg.w_data[29:24];      // R13
               end else if (s_reg.aw_addr == OFS_FLAGS) begin
                  s_next.flags = s_reg.w_data[5:0];
               end else begin
                  s_next.deadline = s_reg.w_data;               // R12
               end
            end
            OFS_DATA: begin
               if (s_reg.st == ATH_SRC_PAY && !s_reg.tv) begin
                  s_next.bvalid = 1'b0;
                  s_next.dwait  = 1'b1;
                  s_next.tv     = 1'b1;
                  s_next.td     = s_reg.w_data[7:0];
                  s_next.ts     = s_reg.first;
                  s_next.te     = s_reg.w_data[DATA_TEND];      // R14
               end else if (s_reg.st == ATH_SRC_IDLE) begin
                  s_next.bresp = RESP_SLVERR;
               end else begin
                  s_next.bvalid = 1'b0;
                  s_next.aw_got = 1'b1;
                  s_next.w_got  = 1'b1;
               end
            end
            default: s_next.bresp = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg       <= '0;
         s_reg.st    <= ATH_SRC_IDLE;
         s_reg.first <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid && !s_reg.dwait;
   assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid && !s_reg.dwait;
   assign s_axi_bvalid  = s_reg.bvalid;
   assign s_axi_bresp   = s_reg.bresp;
   assign s_axi_arready = !s_reg.rvalid;
   assign s_axi_rvalid  = s_reg.rvalid;
   assign s_axi_rdata   = s_reg.rdata;
   assign s_axi_rresp   = s_reg.rresp;
   assign link.tvalid   = s_reg.tv;
   assign link.tdata    = s_reg.td;
   assign link.tstart   = s_reg.ts;
   assign link.tend     = s_reg.te;
endmodule
